// ### hdl/flag_prbs.sv
// Free-running sequence generator that masks the flag bit coding
`timescale 1ns/100ps
module flag_prbs #(
	parameter int W = tx_word_pkg::PRBS_W,
	parameter logic [W-1:0] TAPS = tx_word_pkg::PRBS_TAPS,
	parameter logic [W-1:0] SEED = tx_word_pkg::PRBS_SEED
) (
	input wire logic sys_clk, // Word rate clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic step, // Advance one position
	output logic prbs_bit // Current mask bit
);

	logic [W-1:0] lfsr_q;
	logic [W-1:0] lfsr_d;
	wire feedback = ^(lfsr_q & TAPS);

	assign lfsr_d = step ? {lfsr_q[W-2:0], feedback} : lfsr_q;
	assign prbs_bit = lfsr_q[W-1];

	// Seed must be nonzero or the sequence locks up at all zeros
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			lfsr_q <= SEED;
		else
			lfsr_q <= lfsr_d;
	end

endmodule

// ### hdl/tx_word_pkg.sv
// Constants, encodings and timing counts for the transmit word selector
//
// How it works
// - Flag mode high: user flag rides data words
// - Scramble enable scrambles the flag bit coding
// - Data request alone sends bits 0-15 plus flag
// - Control request sends only bits 0-13
// - Both requests together send a control word
// - No request sends an idle word
// - Flag mode low: internal alternating flag instead
// - Control words never carry a flag bit
// - Lock output rises once clock generator locks
// - Words and strobes taken on rising clock edge
package tx_word_pkg;

	localparam int WORD_W = 16;
	localparam int CTRL_W = 14;

	// Word rate clock, one word per cycle
	localparam int CLK_HZ = 10_000_000;

	// Frequency acquisition time, rounded up to whole cycles
	localparam int LOCK_TIME_MS = 4;
	localparam int LOCK_CYCLES = (LOCK_TIME_MS * CLK_HZ + 999) / 1000;

	// Flag scrambler sequence: x^7 + x^6 + 1
	localparam int PRBS_W = 7;
	localparam logic [PRBS_W-1:0] PRBS_TAPS = 7'h60;
	localparam logic [PRBS_W-1:0] PRBS_SEED = 7'h7f;

	localparam logic ALT_FLAG_RESET = 1'h0;
	localparam logic [WORD_W-1:0] IDLE_WORD = 16'h0000;

	typedef enum logic [2:0]
	{
		WT_IDLE = 3'h1,
		WT_DATA = 3'h2,
		WT_CTRL = 3'h4
	} word_type_e;

endpackage

// ### hdl/tx_word_select.sv
// Transmit word type selection, flag bit source and scrambling
`timescale 1ns/100ps
module tx_word_select #(
	parameter int LOCK_CYCLES = tx_word_pkg::LOCK_CYCLES
) (
	input wire logic sys_clk, // Word rate clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [tx_word_pkg::WORD_W-1:0] word_in, // Parallel word
	input wire logic data_word_request, // Send a data word
	input wire logic control_word_request, // Send a control word
	input wire logic user_flag_input, // User 17th bit
	input wire logic flag_bit_mode_select, // 1: user flag, 0: alternating
	input wire logic flag_scramble_enable, // Scramble flag coding
	output tx_word_pkg::word_type_e word_type_q, // Type of word sent
	output logic [tx_word_pkg::WORD_W-1:0] tx_word_q, // Word payload
	output logic tx_flag_q, // Flag bit sent with data
	output logic tx_flag_valid_q, // Flag bit is part of word
	output logic locked_q // Clock generator locked
);
	import tx_word_pkg::*;

	localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam int PAD_W = WORD_W - CTRL_W;

	logic alt_flag_q;
	logic alt_flag_d;
	logic [CNT_W-1:0] lock_cnt_q;
	logic [CNT_W-1:0] lock_cnt_d;
	logic locked_d;
	word_type_e word_type_d;
	logic [WORD_W-1:0] tx_word_d;
	logic tx_flag_d;
	logic prbs_bit;

	// Control beats data when both are raised
	wire sel_ctrl = control_word_request;
	wire sel_data = data_word_request & ~control_word_request;
	wire sel_idle = ~data_word_request & ~control_word_request;

	// Upper input bits are dropped on control words
	wire [WORD_W-1:0] ctrl_word =
		{{PAD_W{1'b0}}, word_in[CTRL_W-1:0]};

	// Flag source: user bit, or internal alternating bit
	wire raw_flag = flag_bit_mode_select
		? user_flag_input : alt_flag_q;

	// The mask only hides the coding; the far end strips it again
	wire scr_mask = flag_scramble_enable & prbs_bit;
	wire coded_flag = raw_flag ^ scr_mask;

	assign word_type_d = sel_ctrl ? WT_CTRL : (sel_data ? WT_DATA : WT_IDLE);
	assign tx_word_d = sel_ctrl ? ctrl_word : (sel_data ? word_in : IDLE_WORD);
	assign tx_flag_d = sel_data ? coded_flag : 1'b0;

	// Toggle only on data words so the receiver can check the pattern
	assign alt_flag_d = sel_data ? ~alt_flag_q : alt_flag_q;

	// Lock stands in for the clock generator's acquisition time
	assign lock_cnt_d = (lock_cnt_q == LOCK_LAST) ? lock_cnt_q
		: lock_cnt_q + CNT_ONE;
	assign locked_d = locked_q | (lock_cnt_q == LOCK_LAST);

	// Mask steps every word so both ends stay aligned from reset
	flag_prbs #(
		.W(PRBS_W),
		.TAPS(PRBS_TAPS),
		.SEED(PRBS_SEED)
	) flag_prbs_inst (
		.sys_clk(sys_clk),
		.rst(rst),
		.step(1'b1),
		.prbs_bit(prbs_bit)
	);

	// Inputs are captured on the rising word clock edge
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			word_type_q <= WT_IDLE;
			tx_word_q <= IDLE_WORD;
			tx_flag_q <= 1'b0;
			tx_flag_valid_q <= 1'b0;
		end
		else
		begin
			word_type_q <= word_type_d;
			tx_word_q <= tx_word_d;
			tx_flag_q <= tx_flag_d;
			tx_flag_valid_q <= sel_data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			alt_flag_q <= ALT_FLAG_RESET;
		else
			alt_flag_q <= alt_flag_d;
	end

	// Lock is sticky; a real loop losing lock is not modelled
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			lock_cnt_q <= '0;
			locked_q <= 1'b0;
		end
		else
		begin
			lock_cnt_q <= lock_cnt_d;
			locked_q <= locked_d;
		end
	end

	a_user_flag_sent: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sel_data && flag_bit_mode_select && !flag_scramble_enable)
		|=> (tx_flag_q == $past(user_flag_input)) && tx_flag_valid_q)
	else $error("user flag not sent with data word");

	a_flag_scrambled: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sel_data && flag_bit_mode_select && flag_scramble_enable)
		|=> tx_flag_q == ($past(user_flag_input) ^ $past(prbs_bit)))
	else $error("flag bit not scrambled");

	a_data_word_out: assert property (
		@(posedge sys_clk) disable iff (rst)
		(data_word_request && !control_word_request)
		|=> (word_type_q == WT_DATA) && (tx_word_q == $past(word_in)))
	else $error("data word not sent");

	a_ctrl_word_out: assert property (
		@(posedge sys_clk) disable iff (rst)
		control_word_request
		|=> (tx_word_q[CTRL_W-1:0] == $past(word_in[CTRL_W-1:0]))
		&& (tx_word_q[WORD_W-1:CTRL_W] == '0))
	else $error("control word payload wrong");

	a_ctrl_wins: assert property (
		@(posedge sys_clk) disable iff (rst)
		(control_word_request && data_word_request)
		|=> word_type_q == WT_CTRL)
	else $error("control word did not take precedence");

	a_idle_word_out: assert property (
		@(posedge sys_clk) disable iff (rst)
		sel_idle |=> (word_type_q == WT_IDLE) && (tx_word_q == IDLE_WORD))
	else $error("idle word not sent");

	a_alt_flag_used: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sel_data && !flag_bit_mode_select && !flag_scramble_enable)
		|=> tx_flag_q == $past(alt_flag_q))
	else $error("alternating flag not used");

	a_ctrl_no_flag: assert property (
		@(posedge sys_clk) disable iff (rst)
		(word_type_q != WT_DATA) |-> !tx_flag_q && !tx_flag_valid_q)
	else $error("flag bit present outside a data word");

	a_alt_flag_flips: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sel_data && !flag_bit_mode_select && !flag_scramble_enable)
		##1 (sel_data && !flag_bit_mode_select && !flag_scramble_enable)
		|=> tx_flag_q != $past(tx_flag_q))
	else $error("alternating flag did not toggle");

	a_alt_flag_hold: assert property (
		@(posedge sys_clk) disable iff (rst)
		!sel_data |=> $stable(alt_flag_q))
	else $error("alternating flag moved on a non-data word");

	a_lock_timing: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(locked_q) |-> $past(lock_cnt_q) == LOCK_LAST)
	else $error("lock raised at wrong time");

	a_lock_sticky: assert property (
		@(posedge sys_clk) disable iff (rst)
		locked_q |=> locked_q)
	else $error("lock dropped");

	a_alt_flag_scr: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sel_data && !flag_bit_mode_select && flag_scramble_enable)
		|=> tx_flag_q == ($past(alt_flag_q) ^ $past(prbs_bit)))
	else $error("alternating flag not scrambled");

	a_alt_flag_step: assert property (
		@(posedge sys_clk) disable iff (rst)
		sel_data |=> alt_flag_q != $past(alt_flag_q))
	else $error("alternating flag did not step on a data word");

	a_ctrl_word_type: assert property (
		@(posedge sys_clk) disable iff (rst)
		control_word_request |=> (word_type_q == WT_CTRL) && !tx_flag_q)
	else $error("control request did not send a control word");

	a_data_flag_valid: assert property (
		@(posedge sys_clk) disable iff (rst)
		sel_data |=> tx_flag_valid_q)
	else $error("flag valid missing on data word");

	a_lock_early: assert property (
		@(posedge sys_clk) disable iff (rst)
		(lock_cnt_q != LOCK_LAST) |-> !locked_q)
	else $error("lock raised before acquisition time");

	a_lock_rise: assert property (
		@(posedge sys_clk) disable iff (rst)
		(lock_cnt_q == LOCK_LAST) |=> locked_q)
	else $error("lock not raised after acquisition time");

endmodule

// ### sim/rx_flag_model.sv
// Far receiver model that undoes flag scrambling on data words
`timescale 1ns/100ps
module rx_flag_model (
	input wire logic sys_clk, // Word rate clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic flag_scramble_enable, // Set as the transmitter
	input wire logic tx_flag_q, // Flag bit off the link
	output logic rx_flag // Recovered flag
);
	import tx_word_pkg::*;
	logic [PRBS_W-1:0] seq_q;
	logic mask_q;
	// Steps every cycle, idle or not, or it drifts from the sender
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			seq_q <= PRBS_SEED;
			mask_q <= 1'h0;
		end
		else
		begin
			seq_q <= {seq_q[PRBS_W-2:0], ^(seq_q & PRBS_TAPS)};
			mask_q <= seq_q[PRBS_W-1];
		end
	end
	assign rx_flag = tx_flag_q ^ (flag_scramble_enable & mask_q);
endmodule

// ### sim/tx_word_select_tb.sv
// Self-checking bench for the transmit word selector
`timescale 1ns/100ps
module tx_word_select_tb;
	import tx_word_pkg::*;
	logic sys_clk = 0, rst = 1, dreq = 0, creq = 0, uflag = 0;
	logic mode = 0, scr = 0, alt = 0;
	logic [15:0] win = 16'h0000;
	word_type_e wtype;
	logic [15:0] tx_word;
	logic tx_flag, tx_valid, locked, rx_flag;
	int failures = 0, checks = 0;
	// Lock is seen this many edges after reset release
	localparam int LOCK_N = 8;
	tx_word_select #(.LOCK_CYCLES(LOCK_N)) tx_word_select_inst (
		.sys_clk(sys_clk),
		.rst(rst), .word_in(win), .data_word_request(dreq),
		.control_word_request(creq), .user_flag_input(uflag),
		.flag_bit_mode_select(mode), .flag_scramble_enable(scr),
		.word_type_q(wtype), .tx_word_q(tx_word), .tx_flag_q(tx_flag),
		.tx_flag_valid_q(tx_valid), .locked_q(locked));
	rx_flag_model rx_flag_model_inst (.sys_clk(sys_clk), .rst(rst),
		.flag_scramble_enable(scr), .tx_flag_q(tx_flag), .rx_flag(rx_flag));
	initial
		forever #50 sys_clk = ~sys_clk;
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic fail(input string msg);
		failures++;
		$display("FAIL %0t %s", $time, msg);
	endtask
	task automatic chk_word(input word_type_e t, input logic [15:0] w,
		input logic f);
		checks++;
		if (wtype !== t || tx_word !== w || tx_valid !== (t == WT_DATA))
			fail("type, payload or flag valid");
		if ((t == WT_DATA ? rx_flag : tx_flag) !== f)
			fail("flag bit");
	endtask
	task automatic chk_num(input int got, input int exp);
		checks++;
		if (got != exp)
			fail("lock count");
	endtask
	// Receiver runs with the same scramble enable, so it expects the unscrambled flag source
	task automatic xfer(input logic d, input logic c, input logic [15:0] w,
		input logic f, input word_type_e t, input logic [15:0] ew);
		logic ef;
		ef = (d && !c) ? (mode ? f : alt) : 1'h0;
		dreq = d;
		creq = c;
		win = w;
		uflag = f;
		@(posedge sys_clk);
		#10;
		if (d && !c)
			alt = !alt;
		chk_word(t, ew, ef);
	endtask
	task automatic t_user;
		mode = 1;
		xfer(1, 0, 16'ha5c3, 1, WT_DATA, 16'ha5c3);
		xfer(1, 0, 16'h5a3c, 0, WT_DATA, 16'h5a3c);
	endtask
	task automatic t_ctrl;
		xfer(0, 1, 16'hffff, 1, WT_CTRL, 16'h3fff);
		xfer(1, 1, 16'hc001, 1, WT_CTRL, 16'h0001);
		xfer(0, 0, 16'h1234, 1, WT_IDLE, 16'h0000);
	endtask
	task automatic t_alt;
		mode = 0;
		for (int i = 0; i < 7; i++)
			xfer(1, i[1], 16'h00f0, 1, i[1] ? WT_CTRL : WT_DATA,
				16'h00f0);
	endtask
	task automatic t_lock;
		int n;
		n = 0;
		rst = 1;
		alt = 0;
		@(posedge sys_clk);
		#10;
		rst = 0;
		while (locked !== 1'h1 && n < 20)
		begin
			@(posedge sys_clk);
			#10;
			n++;
		end
		chk_num(n, LOCK_N);
	endtask
	task automatic t_scr;
		scr = 1;
		for (int i = 0; i < 12; i++)
		begin
			mode = i[1];
			xfer(1, 0, 16'hbe00 ^ 16'(i), i[0], WT_DATA,
				16'hbe00 ^ 16'(i));
		end
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		#10;
		rst = 0;
		t_user();
		t_ctrl();
		t_alt();
		t_lock();
		t_scr();
		final_report();
	end
	// Whole run is well under a hundred cycles
	initial
	begin
		#100000;
		failures++;
		final_report();
	end
endmodule
